// ---- ctb_core.sv ----
// Coarse trim, backup switchover and power-fail timestamp logic with AXI4-Lite registers
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "ctb_cfg.svh"
module ctb_core
   import ctb_pkg::*;
#(
   parameter logic [15:0] TICKS_PER_SEC = `CTB_TICKS_PER_SEC,
   parameter logic [5:0] SECS_PER_MIN = `CTB_SECS_PER_MIN
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic osc_tick,
   input wire logic main_above_threshold,
   input wire logic oscillator_running_flag,
   input wire ctb_stamp_t live_time,
   output logic clock_output_pin,
   output logic trim_pulse,
   output logic trim_add,
   output logic on_backup,
   output logic watchdog_enable
);
   ctb_state_t s_r;
   ctb_state_t s_nxt;
   logic [7:0] widx;
   logic [7:0] ridx;
   logic wr_go;
   logic rd_go;
   logic per_tick;
   logic sec_wrap;
   logic trim_evt;
   logic [7:0] rbyte;
   logic rhit;
   logic whit;
   logic main_ok;

   assign widx = s_axi_awaddr[9:2];
   assign ridx = s_axi_araddr[9:2];
   // Bus ignored while on backup: no new address handshake is accepted then
   assign s_axi_awready = (s_r.bus == CTB_ST_IDLE) && s_axi_awvalid && s_axi_wvalid
      && !s_r.on_backup;
   assign s_axi_wready = s_axi_awready;
   assign s_axi_arready = (s_r.bus == CTB_ST_IDLE) && s_axi_arvalid && !s_axi_awvalid
      && !s_r.on_backup;
   assign wr_go = s_axi_awready;
   assign rd_go = s_axi_arready;
   assign s_axi_bvalid = (s_r.bus == CTB_ST_BRESP);
   assign s_axi_bresp = s_r.berr ? 2'b10 : 2'b00;
   assign s_axi_rvalid = (s_r.bus == CTB_ST_RDATA);
   assign s_axi_rresp = s_r.rerr ? 2'b10 : 2'b00;
   assign s_axi_rdata = s_r.rdata;
   assign clock_output_pin = s_r.clk_out;
   assign on_backup = s_r.on_backup;
   assign watchdog_enable = s_r.wdt_en;
   assign trim_add = s_r.hours_trim[`CTB_BIT_TRIM_DIR];
   assign main_ok = s_r.vmain_s[1];

   assign per_tick = osc_tick;
   assign sec_wrap = per_tick && (s_r.tick_cnt == TICKS_PER_SEC - 16'h0001);
   // Trim interval: every second in coarse mode, else every minute
   assign trim_evt = sec_wrap && (s_r.clock_ctrl[`CTB_BIT_COARSE]
      || s_r.sec_cnt == SECS_PER_MIN - 6'h01);
   // One pulse per oscillator cycle to add or swallow, two per step
   assign trim_pulse = per_tick && (s_r.trim_left != 10'h000);

   always_comb begin
      rhit = 1'b1;
      unique case (ridx)
         `CTB_IDX_PD_MIN: rbyte = s_r.pd.minutes;
         `CTB_IDX_PD_HOUR: rbyte = s_r.pd.hours;
         `CTB_IDX_PD_DATE: rbyte = s_r.pd.date;
         `CTB_IDX_PD_MTH: rbyte = s_r.pd.month;
         `CTB_IDX_PU_MIN: rbyte = s_r.pu.minutes;
         `CTB_IDX_PU_HOUR: rbyte = s_r.pu.hours;
         `CTB_IDX_PU_DATE: rbyte = s_r.pu.date;
         `CTB_IDX_PU_MTH: rbyte = s_r.pu.month;
         `CTB_IDX_HOURS_TRIM: rbyte = s_r.hours_trim;
         `CTB_IDX_CLOCK_CTRL: rbyte = s_r.clock_ctrl;
         `CTB_IDX_TRIM_AMOUNT: rbyte = s_r.trim_amount;
         `CTB_IDX_BACKUP_CTRL: rbyte = {2'b00, oscillator_running_flag, s_r.power_fail,
            s_r.backup_en, 2'b00, s_r.wdt_en};
         default: begin
            rbyte = 8'h00;
            rhit = 1'b0;
         end
      endcase
      whit = (widx >= `CTB_IDX_PD_MIN) && (widx <= `CTB_IDX_BACKUP_CTRL);
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.vmain_s = {s_r.vmain_s[1:0], main_above_threshold};
      // Bus slave
      unique case (s_r.bus)
         CTB_ST_IDLE: begin
            if (wr_go) begin
               s_nxt.bus = CTB_ST_BRESP;
               s_nxt.berr = !whit;
            end else if (rd_go) begin
               s_nxt.bus = CTB_ST_RDATA;
               s_nxt.rerr = !rhit;
               s_nxt.rdata = {24'h00_0000, rbyte};
            end
         end
         CTB_ST_RDATA: if (s_axi_rready) s_nxt.bus = CTB_ST_IDLE;
         CTB_ST_BRESP: if (s_axi_bready) s_nxt.bus = CTB_ST_IDLE;
         // The fourth code of the two-bit state is illegal; fall back to idle
         default: s_nxt.bus = CTB_ST_IDLE;
      endcase
      if (wr_go && s_axi_wstrb[0]) begin
         unique case (widx)
            `CTB_IDX_PD_MIN: s_nxt.pd.minutes = s_axi_wdata[7:0] & `CTB_MASK_MIN;
            `CTB_IDX_PD_HOUR: s_nxt.pd.hours = s_axi_wdata[7:0] & `CTB_MASK_HOUR;
            `CTB_IDX_PD_DATE: s_nxt.pd.date = s_axi_wdata[7:0] & `CTB_MASK_DATE;
            `CTB_IDX_PD_MTH: s_nxt.pd.month = s_axi_wdata[7:0];
            `CTB_IDX_PU_MIN: s_nxt.pu.minutes = s_axi_wdata[7:0] & `CTB_MASK_MIN;
            `CTB_IDX_PU_HOUR: s_nxt.pu.hours = s_axi_wdata[7:0] & `CTB_MASK_HOUR;
            `CTB_IDX_PU_DATE: s_nxt.pu.date = s_axi_wdata[7:0] & `CTB_MASK_DATE;
            `CTB_IDX_PU_MTH: s_nxt.pu.month = s_axi_wdata[7:0];
            `CTB_IDX_HOURS_TRIM: s_nxt.hours_trim = s_axi_wdata[7:0];
            `CTB_IDX_CLOCK_CTRL: s_nxt.clock_ctrl = s_axi_wdata[7:0];
            `CTB_IDX_TRIM_AMOUNT: s_nxt.trim_amount = s_axi_wdata[7:0];
            `CTB_IDX_BACKUP_CTRL: begin
               s_nxt.backup_en = s_axi_wdata[`CTB_BIT_BACKUP_EN];
               s_nxt.wdt_en = s_axi_wdata[`CTB_BIT_WDT_EN];
               // Writing zero clears the flag and wipes both stamp sets
               if (!s_axi_wdata[`CTB_BIT_PWR_FAIL] && s_r.power_fail) begin
                  s_nxt.power_fail = 1'b0;
                  s_nxt.pd = '0;
                  s_nxt.pu = '0;
               end
            end
            default: ;
         endcase
      end
      // Switchover only possible with backup input enabled
      if (!s_r.on_backup && !main_ok && s_r.backup_en) begin
         s_nxt.on_backup = 1'b1;
         s_nxt.wdt_en = 1'b0;
         if (!s_r.power_fail) begin
            // Reserved bits forced to zero even if the live counters carry junk
            s_nxt.pd = live_time & {`CTB_MASK_MIN, `CTB_MASK_HOUR, `CTB_MASK_DATE,
               `CTB_MASK_MTH};
            s_nxt.power_fail = 1'b1;
         end
      end else if (s_r.on_backup && main_ok) begin
         s_nxt.on_backup = 1'b0;
         // Power-up stamp belongs to the failure just logged
         if (s_r.power_fail && s_r.pu == '0) begin
            s_nxt.pu = live_time & {`CTB_MASK_MIN, `CTB_MASK_HOUR, `CTB_MASK_DATE,
               `CTB_MASK_MTH};
         end
      end
      // Timekeeping divider and trim keep running on backup
      if (per_tick) begin
         s_nxt.tick_cnt = sec_wrap ? 16'h0000 : s_r.tick_cnt + 16'h0001;
         if (s_r.trim_left != 10'h000) s_nxt.trim_left = s_r.trim_left - 10'h001;
         if (sec_wrap) begin
            s_nxt.half_wave = 1'b0;
            s_nxt.sec_cnt = (s_r.sec_cnt == SECS_PER_MIN - 6'h01) ? 6'h00
               : s_r.sec_cnt + 6'h01;
         end else if (s_r.tick_cnt == {1'b0, TICKS_PER_SEC[15:1]} - 16'h0001) begin
            s_nxt.half_wave = 1'b1;
         end
         if (trim_evt) s_nxt.trim_left = {1'b0, s_r.trim_amount, 1'b0};
      end
      // Trimmed 1 Hz square wave, driven only in coarse mode with the pin enable set, suppressed on backup
      s_nxt.clk_out = s_r.clock_ctrl[`CTB_BIT_COARSE] && s_r.clock_ctrl[`CTB_BIT_CLOCK_OUTPUT_PIN_EN]
         && !s_r.on_backup && !s_nxt.half_wave;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.vmain_s <= 3'b111;
      end else begin
         s_r <= s_nxt;
      end
   end

   a_backup_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_r.on_backup) |-> $past(s_r.backup_en))
      else $error("Switched to backup without enable");
   a_clock_output_pin_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.on_backup |=> !clock_output_pin || !s_r.on_backup)
      else $error("Clock output driven on backup");
   a_wdt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_r.on_backup) |-> !watchdog_enable)
      else $error("Watchdog enable not cleared");
   a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_r.on_backup) |-> s_r.power_fail)
      else $error("Power-fail flag not set");
   a_stamp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ($past(s_r.power_fail) && s_r.power_fail && !$past(wr_go)) |-> $stable(s_r.pd))
      else $error("Stamp overwritten while flag set");
   a_clear_wipe: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(s_r.power_fail) |-> (s_r.pd == '0 && s_r.pu == '0))
      else $error("Stamps not cleared with flag");
   a_bus_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      s_r.on_backup |-> !s_axi_awready && !s_axi_arready)
      else $error("Bus accepted on backup");
   a_trim_len: assert property (@(posedge aclk) disable iff (!aresetn)
      (per_tick && trim_evt) |=> s_r.trim_left == {1'b0, $past(s_r.trim_amount), 1'b0})
      else $error("Trim count wrong");
   a_min_bit7: assert property (@(posedge aclk) disable iff (!aresetn)
      !s_r.pd.minutes[7] && !s_r.pu.minutes[7] && s_r.pd.date[7:6] == 2'b00)
      else $error("Reserved stamp bit set");
endmodule
`default_nettype wire

// ---- ctb_cfg.svh ----
// Register offsets, field positions and timing counts for the trim/backup/timestamp block
`ifndef CTB_CFG_SVH
`define CTB_CFG_SVH
`define CTB_IDX_PD_MIN 8'h18
`define CTB_IDX_PD_HOUR 8'h19
`define CTB_IDX_PD_DATE 8'h1A
`define CTB_IDX_PD_MTH 8'h1B
`define CTB_IDX_PU_MIN 8'h1C
`define CTB_IDX_PU_HOUR 8'h1D
`define CTB_IDX_PU_DATE 8'h1E
`define CTB_IDX_PU_MTH 8'h1F
`define CTB_IDX_HOURS_TRIM 8'h20
`define CTB_IDX_CLOCK_CTRL 8'h21
`define CTB_IDX_TRIM_AMOUNT 8'h22
`define CTB_IDX_BACKUP_CTRL 8'h23
`define CTB_BIT_TRIM_DIR 7
`define CTB_BIT_CLOCK_OUTPUT_PIN_EN 6
`define CTB_BIT_COARSE 2
`define CTB_BIT_OSC_RUN 5
`define CTB_BIT_PWR_FAIL 4
`define CTB_BIT_BACKUP_EN 3
`define CTB_BIT_WDT_EN 0
`define CTB_MASK_MIN 8'h7F
`define CTB_MASK_HOUR 8'h7F
`define CTB_MASK_DATE 8'h3F
`define CTB_MASK_MTH 8'hFF
`define CTB_OSC_HZ 32768
`define CTB_TICKS_PER_SEC 16'h8000
`define CTB_SECS_PER_MIN 6'h3C
`endif

// ---- ctb_pkg.sv ----
// Types for the trim/backup/timestamp block
package ctb_pkg;
   typedef enum logic [1:0] {CTB_ST_IDLE, CTB_ST_RDATA, CTB_ST_BRESP} ctb_bus_t;
   typedef struct packed {
      logic [7:0] minutes;
      logic [7:0] hours;
      logic [7:0] date;
      logic [7:0] month;
   } ctb_stamp_t;
   typedef struct packed {
      ctb_bus_t bus;
      logic [31:0] rdata;
      logic rerr;
      logic berr;
      logic [7:0] hours_trim;
      logic [7:0] clock_ctrl;
      logic [7:0] trim_amount;
      logic backup_en;
      logic power_fail;
      logic wdt_en;
      ctb_stamp_t pd;
      ctb_stamp_t pu;
      logic [2:0] vmain_s;
      logic on_backup;
      logic [15:0] tick_cnt;
      logic [5:0] sec_cnt;
      logic [9:0] trim_left;
      logic half_wave;
      logic clk_out;
   } ctb_state_t;
endpackage

// ---- ctb_supply_model.sv ----
// Supply, oscillator and live time model at the far side of the block
`timescale 1ns/10ps
`default_nettype none
module ctb_supply_model
   import ctb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic main_ok,
   input wire ctb_stamp_t time_in,
   output logic osc_tick,
   output logic main_above_threshold,
   output logic oscillator_running_flag,
   output ctb_stamp_t live_time
);
   int start_cnt;
   // Oscillator runs free; the running flag waits out a start-up delay
   always @(posedge aclk) begin
      if (!aresetn) begin
         start_cnt <= 0;
         osc_tick <= 1'b0;
         oscillator_running_flag <= 1'b0;
      end else begin
         osc_tick <= ~osc_tick;
         if (start_cnt < 40) start_cnt <= start_cnt + 1;
         oscillator_running_flag <= (start_cnt >= 40);
      end
   end
   assign main_above_threshold = main_ok;
   assign live_time = time_in;
endmodule
`default_nettype wire

// ---- coarse_trim_backup_timestamp_test.sv ----
// Self-checking bench for the trim, backup and timestamp block
`timescale 1ns/10ps
`default_nettype none
module coarse_trim_backup_timestamp_test;
   import ctb_pkg::*;
   localparam int TPS = 8;
   localparam int SPM = 4;
   logic aclk = 0, aresetn = 0, main_ok = 1;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic [3:0] wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, osc_tick, main_hi, osc_run;
   logic clk_pin, tpulse, tadd, on_bk, wdt;
   logic [1:0] bresp, rresp;
   ctb_stamp_t tin = 0, live, sa, sb;
   int err_total = 0, cmp_count = 0, cyc = 0;
   int mdl[int];
   logic [7:0] tc[4] = '{8'h44, 8'h00, 8'h04, 8'h44};
   int ta[4] = '{1, 1, 0, 2};
   always #50 aclk = ~aclk;
   ctb_supply_model PM (.aclk(aclk), .aresetn(aresetn), .main_ok(main_ok), .time_in(tin),
      .osc_tick(osc_tick), .main_above_threshold(main_hi),
      .oscillator_running_flag(osc_run), .live_time(live));
   ctb_core #(.TICKS_PER_SEC(16'(TPS)), .SECS_PER_MIN(6'(SPM))) DUT (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .osc_tick(osc_tick), .main_above_threshold(main_hi),
      .oscillator_running_flag(osc_run), .live_time(live), .clock_output_pin(clk_pin),
      .trim_pulse(tpulse), .trim_add(tadd), .on_backup(on_bk), .watchdog_enable(wdt));
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Long enough for every scenario with generous slack
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= {22'h0, idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do @(posedge aclk); while ((awready & wready) !== 1'b1);
      awvalid <= 0;
      wvalid <= 0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 0;
      chk({30'h0, r}, (idx < 8'h18 || idx > 8'h23) ? 2 : 0);
      if (idx >= 8'h18 && idx <= 8'h22) mdl[idx] = d;
   endtask
   task automatic rdc(input logic [7:0] idx);
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= {22'h0, idx, 2'b00};
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 0;
      chk(d, mdl.exists(idx) ? mdl[idx] : 0);
      chk({30'h0, r}, mdl.exists(idx) ? 0 : 2);
   endtask
   function automatic ctb_stamp_t mk();
      logic f;
      f = 1'($urandom);
      mk.minutes = {1'b0, 3'($urandom % 6), 4'($urandom % 10)};
      mk.hours = {1'b0, f, f ? 2'($urandom % 4) : 2'($urandom % 3), 4'($urandom % 10)};
      mk.date = {2'b00, 2'($urandom % 4), 4'($urandom % 10)};
      mk.month = {3'($urandom % 7 + 1), 1'b0, 4'($urandom % 10)};
   endfunction
   task automatic setst(input int b, input ctb_stamp_t s);
      mdl[b] = s.minutes;
      mdl[b + 1] = s.hours;
      mdl[b + 2] = s.date;
      mdl[b + 3] = s.month;
   endtask
   task automatic rdall();
      for (int i = 8'h18; i <= 8'h1f; i++) rdc(8'(i));
      rdc(8'h23);
   endtask
   // Main power drop and return; trimming must keep going on backup
   task automatic pcycle(input ctb_stamp_t a, input ctb_stamp_t b);
      int n, hi, np;
      tin <= a;
      @(posedge aclk);
      main_ok <= 0;
      n = 0;
      do begin @(negedge aclk); n++; end while (on_bk !== 1'b1 && n < 20);
      chk(32'(n < 20), 1);
      chk({31'h0, wdt}, 0);
      hi = 0;
      np = 0;
      repeat (30) begin
         @(negedge aclk);
         if (clk_pin !== 1'b0) hi++;
         if (tpulse === 1'b1) np++;
      end
      chk(hi, 0);
      chk(32'(np > 0), 1);
      @(posedge aclk);
      tin <= b;
      @(posedge aclk);
      main_ok <= 1;
      n = 0;
      do begin @(negedge aclk); n++; end while (on_bk !== 1'b0 && n < 20);
      chk(32'(n < 20), 1);
      repeat (4) @(posedge aclk);
   endtask
   task automatic meas(input int k, output int np, output int nc);
      logic last;
      wr(8'h21, tc[k]);
      wr(8'h22, 8'(ta[k]));
      // Let trim cycles left from the previous setting drain first
      repeat (8) @(posedge aclk);
      np = 0;
      nc = 0;
      last = clk_pin;
      // Ticks come every other cycle, so this spans 64 oscillator cycles
      repeat (128) begin
         @(negedge aclk);
         if (tpulse === 1'b1) np++;
         if (clk_pin === 1'b1 && last === 1'b0) nc++;
         last = clk_pin;
      end
   endtask
   initial begin
      void'($urandom(32'h0c75));
      ta[1] = 2 * 32768 * 60 / (1000000 * 2);
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      for (int i = 8'h18; i <= 8'h22; i++) mdl[i] = 0;
      for (int i = 8'h17; i <= 8'h22; i++) rdc(8'(i));
      rdc(8'h24);
      wr(8'h30, 8'h5a);
      for (int k = 0; k < 4; k++) begin
         int e, t, np, nc;
         logic dir;
         dir = 1'($urandom);
         wr(8'h20, {dir, 7'($urandom)});
         chk({31'h0, tadd}, {31'h0, dir});
         meas(k, np, nc);
         e = 128 * ta[k] / (tc[k][2] ? TPS : TPS * SPM);
         t = 2 * ta[k];
         chk(32'(np >= e - t && np <= e + t), 1);
         e = (tc[k] == 8'h44) ? 64 / TPS : 0;
         chk(32'(nc >= e / 2 && nc <= 2 * e), 1);
         rdc(8'h20);
      end
      for (int n = 0; n < 200 && osc_run !== 1'b1; n++) @(posedge aclk);
      wr(8'h23, 8'h09);
      mdl[8'h23] = 8'h29;
      rdc(8'h23);
      sa = mk();
      sb = mk();
      pcycle(sa, sb);
      setst(8'h18, sa);
      setst(8'h1c, sb);
      mdl[8'h23] = 8'h38;
      rdall();
      pcycle(mk(), mk());
      rdall();
      wr(8'h23, 8'h08);
      setst(8'h18, 0);
      setst(8'h1c, 0);
      mdl[8'h23] = 8'h28;
      rdall();
      wr(8'h21, 8'h00);
      rdc(8'h21);
      close_out();
   end
endmodule
`default_nettype wire
